//--- logic/rpc_top.sv
// Overview of operation
// RULE_01: Grounded top select picks top preset, lamp on, only its status sinks.
// RULE_02: Grounded first reduced select picks that preset; only its status sinks.
// RULE_03: Grounded second reduced select picks that preset; only its status sinks.
// RULE_04: Grounded auto select lights auto lamp; only auto status sinks.
// RULE_05: Auto mode uses external controller level, zero if none fitted.
// RULE_06: Momentary select is held until a different selection arrives.
// RULE_07: From mid, seven increase closures raise output; further ones ignored.
// RULE_08: From top, fifteen decrease closures lower output; then ignored at bottom.
// RULE_09: Drive off then on recentres trim; fifteen plus seven reaches mid.
// RULE_10: Held inhibit blocks modulator drive at once; output zero.
// RULE_11: Released inhibit restores selected level at once, no reset needed.
// RULE_12: Overvoltage forces output near zero while the fault lasts.
// RULE_13: Overvoltage sinks both overvoltage and weak-drive remote alarms.
// RULE_14: Fault clear restores output and opens remote alarms, no reset.
// RULE_15: Overvoltage and weak-drive lamps light and stay lit after clear.
// RULE_16: Latched lamps clear only on alarm-reset press and release.
// RULE_17: Drive-off command stops power stage; drive-on restores selected level.
// RULE_18: Trim is sixteen-step saturating counter, reset eight, one step per closure.
// RULE_19: Remote inputs are synchronised, debounced, acted on once per closure.
// RULE_20: Remote select and trim accepted only with selector in remote.
`timescale 1ns/1ps
module rpc_top #(
    parameter int unsigned LEVEL_W       = 8,
    parameter int unsigned STABLE_CYCLES = rpc_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // Remote grounded inputs, low while closed
    input  wire logic               sel_top_n_in,
    input  wire logic               sel_red1_n_in,
    input  wire logic               sel_red2_n_in,
    input  wire logic               sel_auto_n_in,
    input  wire logic               trim_up_in,
    input  wire logic               trim_down_in,
    input  wire logic               inhibit_n_in,
    input  wire logic               alarm_reset_n_in,
    // Control inputs
    input  wire logic               remote_mode_in,
    input  wire logic               drive_stage_off_button_in,
    input  wire logic               drive_stage_on_button_in,
    input  wire logic               overvoltage_in,
    input  wire logic               auto_fitted_in,
    input  wire logic [LEVEL_W-1:0] auto_level_in,
    input  wire logic [LEVEL_W-1:0] preset_top_in,
    input  wire logic [LEVEL_W-1:0] preset_red1_in,
    input  wire logic [LEVEL_W-1:0] preset_red2_in,
    // Outputs
    output logic [LEVEL_W-1:0]      power_level_out,
    output logic [3:0]              trim_pos_out,
    output logic                    drive_stage_on_out,
    output logic                    modulator_enable_out,
    output rpc_pkg::rpc_status_s    level_lamp_out,
    output rpc_pkg::rpc_status_s    level_status_oe_out,
    output rpc_pkg::rpc_alarm_s     alarm_lamp_out,
    output rpc_pkg::rpc_alarm_s     alarm_remote_oe_out
);

    // ------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------
    logic [rpc_pkg::N_REMOTE-1:0] pins_n;
    logic [rpc_pkg::N_REMOTE-1:0] held;
    logic [rpc_pkg::N_REMOTE-1:0] press;
    logic [rpc_pkg::N_REMOTE-1:0] rel;

    // Trim pins are grounded closures like the rest
    assign pins_n = {alarm_reset_n_in, inhibit_n_in, trim_down_in, trim_up_in,
                     sel_auto_n_in, sel_red2_n_in, sel_red1_n_in, sel_top_n_in};

    genvar gi;
    generate
        for (gi = 0; gi < rpc_pkg::N_REMOTE; gi++) begin : g_in
            rpc_sync #(
                .STABLE_CYCLES (STABLE_CYCLES)
            ) u_sync (
                .clk_in      (clk_in),
                .rst_n_in    (rst_n_in),
                .pin_n_in    (pins_n[gi]),
                .level_out   (held[gi]),
                .press_out   (press[gi]),
                .release_out (rel[gi])
            ); // RULE_19
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]         rm;
        logic [1:0]         ovs;
        logic [1:0]         offs;
        logic [1:0]         ons;
        logic               off_d;
        logic               on_d;
        rpc_pkg::rpc_level_e level;
        logic               stage_on;
        logic               ovv_lamp;
        logic               weak_lamp;
        logic [LEVEL_W-1:0] power;
        logic               mod_en;
        logic [3:0]         lamps;
        logic [1:0]         alarm_oe;
        logic [3:0]         trim;
    } rpc_top_s;

    rpc_top_s st_r;
    rpc_top_s st_nxt;

    logic       remote;
    logic       ovv;
    logic       off_edge;
    logic       on_edge;
    logic       recentre;
    logic [3:0] trim_pos;

    assign remote   = st_r.rm[1];
    assign ovv      = st_r.ovs[1];
    assign off_edge = st_r.offs[1] & ~st_r.off_d;
    assign on_edge  = st_r.ons[1] & ~st_r.on_d;
    // Recentre when the stage comes back on after being off
    assign recentre = on_edge & ~st_r.stage_on & ~off_edge; // RULE_09

    // ------------------------------------------------------------------
    // Trim
    // ------------------------------------------------------------------
    rpc_trim u_trim (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .recentre_in (recentre),
        .up_in       (press[rpc_pkg::IDX_TRIM_UP] & remote),  // RULE_20
        .down_in     (press[rpc_pkg::IDX_TRIM_DN] & remote),  // RULE_20
        .pos_out     (trim_pos)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [LEVEL_W-1:0] base;
    logic               blocked;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rm    = {st_r.rm[0], remote_mode_in};
        st_nxt.ovs   = {st_r.ovs[0], overvoltage_in};
        st_nxt.offs  = {st_r.offs[0], drive_stage_off_button_in};
        st_nxt.ons   = {st_r.ons[0], drive_stage_on_button_in};
        st_nxt.off_d = st_r.offs[1];
        st_nxt.on_d  = st_r.ons[1];

        // Later press of a different select wins; lowest index first if tied
        if (remote) begin // RULE_20
            if (press[rpc_pkg::IDX_SEL_TOP]) begin
                st_nxt.level = rpc_pkg::RPC_LVL_TOP; // RULE_01
            end else if (press[rpc_pkg::IDX_SEL_RED1]) begin
                st_nxt.level = rpc_pkg::RPC_LVL_RED1; // RULE_02
            end else if (press[rpc_pkg::IDX_SEL_RED2]) begin
                st_nxt.level = rpc_pkg::RPC_LVL_RED2; // RULE_03
            end else if (press[rpc_pkg::IDX_SEL_AUTO]) begin
                st_nxt.level = rpc_pkg::RPC_LVL_AUTO; // RULE_04
            end
        end // RULE_06

        // Off wins if both arrive together
        if (off_edge) begin
            st_nxt.stage_on = 1'b0; // RULE_17
        end else if (on_edge) begin
            st_nxt.stage_on = 1'b1; // RULE_17
        end

        // Lamps latch; set wins over the reset release
        if (rel[rpc_pkg::IDX_ALM_RST]) begin
            st_nxt.ovv_lamp  = 1'b0; // RULE_16
            st_nxt.weak_lamp = 1'b0; // RULE_16
        end
        if (ovv) begin
            st_nxt.ovv_lamp  = 1'b1; // RULE_15
            st_nxt.weak_lamp = 1'b1; // RULE_15
        end

        unique case (st_r.level)
            rpc_pkg::RPC_LVL_TOP:  base = preset_top_in;
            rpc_pkg::RPC_LVL_RED1: base = preset_red1_in;
            rpc_pkg::RPC_LVL_RED2: base = preset_red2_in;
            rpc_pkg::RPC_LVL_AUTO: base = auto_fitted_in ? auto_level_in : '0; // RULE_05
            default:               base = '0;
        endcase

        // Next stage state, so power drops in the cycle the stage reports off
        blocked = held[rpc_pkg::IDX_INHIBIT] | ovv | ~st_nxt.stage_on; // RULE_10 RULE_12 RULE_17

        // Trim is reported separately; the analog stage applies the step
        st_nxt.power    = blocked ? '0 : base; // RULE_11 RULE_14
        st_nxt.mod_en   = ~held[rpc_pkg::IDX_INHIBIT] & ~ovv; // RULE_10 RULE_11
        st_nxt.lamps    = st_r.level;
        st_nxt.alarm_oe = {ovv, ovv}; // RULE_13 RULE_14
        st_nxt.trim     = trim_pos;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r          <= '0;
            st_r.level    <= rpc_pkg::LEVEL_RESET;
            st_r.stage_on <= 1'b1;
            st_r.lamps    <= rpc_pkg::LEVEL_RESET;
            st_r.trim     <= rpc_pkg::TRIM_MID; // RULE_18
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign power_level_out      = st_r.power;
    assign trim_pos_out         = st_r.trim;
    assign drive_stage_on_out   = st_r.stage_on;
    assign modulator_enable_out = st_r.mod_en;
    // Status sinks (oe high) exactly for the selected level
    assign level_lamp_out       = rpc_pkg::rpc_status_s'({st_r.lamps[0], st_r.lamps[1],
                                                          st_r.lamps[2], st_r.lamps[3]});
    assign level_status_oe_out  = rpc_pkg::rpc_status_s'({st_r.lamps[0], st_r.lamps[1],
                                                          st_r.lamps[2], st_r.lamps[3]});
    assign alarm_lamp_out       = rpc_pkg::rpc_alarm_s'({st_r.ovv_lamp, st_r.weak_lamp});
    assign alarm_remote_oe_out  = rpc_pkg::rpc_alarm_s'(st_r.alarm_oe);

endmodule

//--- logic/rpc_pkg.sv
package rpc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned DEBOUNCE_TIME_US = 10;
    localparam int unsigned DEBOUNCE_CYCLES =
        (DEBOUNCE_TIME_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Trim counter
    // ------------------------------------------------------------------
    localparam int unsigned TRIM_W   = 4;
    localparam logic [3:0]  TRIM_MID = 4'h8;
    localparam logic [3:0]  TRIM_MAX = 4'hF;
    localparam logic [3:0]  TRIM_MIN = 4'h0;

    // ------------------------------------------------------------------
    // Level selection, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RPC_LVL_TOP  = 4'h1,
        RPC_LVL_RED1 = 4'h2,
        RPC_LVL_RED2 = 4'h4,
        RPC_LVL_AUTO = 4'h8
    } rpc_level_e;

    localparam rpc_level_e LEVEL_RESET = RPC_LVL_RED2;
    localparam int unsigned N_REMOTE   = 8;

    // Index of each remote grounded input in the debounce bank
    localparam int unsigned IDX_SEL_TOP  = 0;
    localparam int unsigned IDX_SEL_RED1 = 1;
    localparam int unsigned IDX_SEL_RED2 = 2;
    localparam int unsigned IDX_SEL_AUTO = 3;
    localparam int unsigned IDX_TRIM_UP  = 4;
    localparam int unsigned IDX_TRIM_DN  = 5;
    localparam int unsigned IDX_INHIBIT  = 6;
    localparam int unsigned IDX_ALM_RST  = 7;

    typedef struct packed {
        logic top;
        logic red1;
        logic red2;
        logic autom;
    } rpc_status_s;

    typedef struct packed {
        logic ovv;
        logic weak_drive;
    } rpc_alarm_s;

endpackage

//--- logic/rpc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser plus debounce; press pulses on a settled closure
module rpc_sync #(
    parameter int unsigned STABLE_CYCLES = rpc_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_n_in,
    output logic      level_out,
    output logic      press_out,
    output logic      release_out
);
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        level;
        logic        press;
        logic        rel;
        logic [31:0] cnt;
    } rpc_sync_s;

    rpc_sync_s st_r;
    rpc_sync_s st_nxt;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = ~pin_n_in;
        st_nxt.s2    = st_r.s1;
        st_nxt.press = 1'b0;
        st_nxt.rel   = 1'b0;
        if (st_r.s2 == st_r.level) begin
            st_nxt.cnt = 32'h0;
        end else if (st_r.cnt >= STABLE_CYCLES - 1) begin
            st_nxt.cnt   = 32'h0;
            st_nxt.level = st_r.s2;
            st_nxt.press = st_r.s2;
            st_nxt.rel   = ~st_r.s2;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out   = st_r.level;
    assign press_out   = st_r.press;
    assign release_out = st_r.rel;
endmodule

//--- logic/rpc_trim.sv
`timescale 1ns/1ps
// Saturating trim position
module rpc_trim (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        recentre_in,
    input  wire logic        up_in,
    input  wire logic        down_in,
    output logic [3:0]       pos_out
);
    typedef struct packed {
        logic [3:0] pos;
    } rpc_trim_s;

    rpc_trim_s st_r;
    rpc_trim_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (recentre_in) begin
            st_nxt.pos = rpc_pkg::TRIM_MID; // RULE_09
        end else if (up_in && !down_in && st_r.pos != rpc_pkg::TRIM_MAX) begin
            st_nxt.pos = st_r.pos + 4'h1; // RULE_07
        end else if (down_in && !up_in && st_r.pos != rpc_pkg::TRIM_MIN) begin
            st_nxt.pos = st_r.pos - 4'h1; // RULE_08
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r.pos <= rpc_pkg::TRIM_MID; // RULE_18
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pos_out = st_r.pos;
endmodule

//--- tb/rpc_remote_site.sv
`timescale 1ns/1ps
// Remote site: a closed switch grounds its line, an open line rests high on its pull-up
module rpc_remote_site (
    input  wire logic [7:0] close_in,
    output logic      [7:0] pin_n_out
);
    assign pin_n_out = ~close_in;
endmodule

//--- tb/rpc_top_asserts.sv
`timescale 1ns/1ps
module rpc_top_asserts #(
    parameter int unsigned LEVEL_W = 8
) (
    input wire logic                 clk_in,
    input wire logic                 rst_n_in,
    input wire logic                 alarm_reset_n_in,
    input wire logic                 overvoltage_in,
    input wire logic [LEVEL_W-1:0]   power_level_out,
    input wire logic [3:0]           trim_pos_out,
    input wire logic                 drive_stage_on_out,
    input wire logic                 modulator_enable_out,
    input wire rpc_pkg::rpc_status_s level_lamp_out,
    input wire rpc_pkg::rpc_status_s level_status_oe_out,
    input wire rpc_pkg::rpc_alarm_s  alarm_lamp_out,
    input wire rpc_pkg::rpc_alarm_s  alarm_remote_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Five samples cover the two sync flops and the output register
    sequence s_ovv_held;
        overvoltage_in [*5];
    endsequence
    sequence s_ovv_gone;
        !overvoltage_in [*5];
    endsequence
    a_status_one_hot: assert property ($onehot(level_status_oe_out))
        else $error("level status not one-hot");
    a_lamp_status_match: assert property (level_lamp_out == level_status_oe_out)
        else $error("level lamp differs from status");
    a_inhibit_zero_power: assert property (!modulator_enable_out |-> power_level_out == '0)
        else $error("power while modulator blocked");
    a_stage_off_zero: assert property (!drive_stage_on_out |-> power_level_out == '0)
        else $error("power while stage off");
    a_ovv_shutback: assert property (s_ovv_held |-> power_level_out == '0
        && alarm_remote_oe_out == 2'h3) else $error("fault not shut back or alarmed");
    a_ovv_release: assert property (s_ovv_gone |-> alarm_remote_oe_out == 2'h0)
        else $error("remote alarm held after fault");
    a_ovv_lamp_set: assert property (s_ovv_held |-> alarm_lamp_out == 2'h3)
        else $error("alarm lamps not lit");
    a_lamp_clear_reset: assert property ($fell(alarm_lamp_out.ovv)
        |-> alarm_reset_n_in && $past(alarm_reset_n_in, 3)) else $error("lamp cleared early");
    a_trim_one_step: assert property ($changed(trim_pos_out) |-> trim_pos_out == 4'h8
        || (trim_pos_out == $past(trim_pos_out) + 4'h1 && trim_pos_out != 4'h0)
        || (trim_pos_out == $past(trim_pos_out) - 4'h1 && trim_pos_out != 4'hF))
        else $error("trim moved more than one step");
endmodule

bind rpc_top rpc_top_asserts #(.LEVEL_W(LEVEL_W)) u_rpc_top_asserts (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .alarm_reset_n_in(alarm_reset_n_in),
    .overvoltage_in(overvoltage_in), .power_level_out(power_level_out),
    .trim_pos_out(trim_pos_out), .drive_stage_on_out(drive_stage_on_out),
    .modulator_enable_out(modulator_enable_out), .level_lamp_out(level_lamp_out),
    .level_status_oe_out(level_status_oe_out), .alarm_lamp_out(alarm_lamp_out),
    .alarm_remote_oe_out(alarm_remote_oe_out));

//--- tb/test_remote_power_control_and_alarm_latch.sv
`timescale 1ns/1ps
module test_remote_power_control_and_alarm_latch;
    logic                 clk_in      = 1'b0;
    logic                 rst_n_in    = 1'b0;
    logic [7:0]           site_close  = 8'h00;
    logic [7:0]           pin_n;
    logic                 remote_mode = 1'b1;
    logic                 off_btn     = 1'b0;
    logic                 on_btn      = 1'b0;
    logic                 ovv         = 1'b0;
    logic                 fitted      = 1'b1;
    logic [7:0]           auto_lvl    = 8'h3C;
    logic [7:0]           power;
    logic [3:0]           trim;
    logic                 stage_on;
    logic                 mod_en;
    rpc_pkg::rpc_status_s lamp;
    rpc_pkg::rpc_status_s oe;
    rpc_pkg::rpc_alarm_s  alm_lamp;
    rpc_pkg::rpc_alarm_s  alm_oe;
    int                   num_errors = 0;
    int                   compares   = 0;
    int                   cycles     = 0;

    always #2.5 clk_in = ~clk_in;

    rpc_remote_site u_rpc_remote_site (.close_in(site_close), .pin_n_out(pin_n));

    // Short debounce keeps each closure to a couple of dozen cycles
    rpc_top #(.LEVEL_W(8), .STABLE_CYCLES(4)) u_rpc_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .sel_top_n_in(pin_n[0]), .sel_red1_n_in(pin_n[1]), .sel_red2_n_in(pin_n[2]),
        .sel_auto_n_in(pin_n[3]), .trim_up_in(pin_n[4]), .trim_down_in(pin_n[5]),
        .inhibit_n_in(pin_n[6]), .alarm_reset_n_in(pin_n[7]),
        .remote_mode_in(remote_mode), .drive_stage_off_button_in(off_btn),
        .drive_stage_on_button_in(on_btn), .overvoltage_in(ovv), .auto_fitted_in(fitted),
        .auto_level_in(auto_lvl), .preset_top_in(8'hC8), .preset_red1_in(8'h96),
        .preset_red2_in(8'h64), .power_level_out(power), .trim_pos_out(trim),
        .drive_stage_on_out(stage_on), .modulator_enable_out(mod_en),
        .level_lamp_out(lamp), .level_status_oe_out(oe),
        .alarm_lamp_out(alm_lamp), .alarm_remote_oe_out(alm_oe));

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic press(input int idx);
        site_close[idx] = 1'b1;
        wait_n(12);
        site_close[idx] = 1'b0;
        wait_n(12);
    endtask

    task automatic button(input bit turn_on);
        on_btn = turn_on;
        off_btn = !turn_on;
        wait_n(4);
        on_btn = 1'b0;
        off_btn = 1'b0;
        wait_n(8);
    endtask

    task automatic t_select();
        logic [7:0] lvl;
        for (int i = 0; i < 4; i++) begin
            press(i);
            lvl = i == 0 ? 8'hC8 : i == 1 ? 8'h96 : i == 2 ? 8'h64 : auto_lvl;
            check(16'(oe), 16'(4'h8 >> i));
            check(16'(lamp), 16'(4'h8 >> i));
            check(16'(power), 16'(lvl));
        end
        fitted = 1'b0;
        wait_n(4);
        check(16'(power), 16'h0000);
        fitted = 1'b1;
    endtask

    task automatic t_local();
        remote_mode = 1'b0;
        wait_n(4);
        press(0);
        press(4);
        check(16'(oe), 16'h0001);
        check(16'(trim), 16'h0008);
        remote_mode = 1'b1;
        wait_n(4);
    endtask

    task automatic t_trim();
        site_close[4] = 1'b1;
        wait_n(2);
        site_close[4] = 1'b0;
        wait_n(12);
        check(16'(trim), 16'h0008);
        for (int i = 1; i <= 8; i++) begin
            press(4);
            check(16'(trim), 16'(i < 8 ? 8 + i : 15));
        end
        for (int i = 1; i <= 16; i++) begin
            press(5);
            check(16'(trim), 16'(i < 16 ? 15 - i : 0));
        end
        repeat (15) press(4);
        repeat (7) press(5);
        check(16'(trim), 16'h0008);
        press(4);
        button(1'b0);
        check(16'(stage_on), 16'h0000);
        check(16'(power), 16'h0000);
        button(1'b1);
        check(16'(trim), 16'h0008);
        check(16'(power), 16'h0064);
    endtask

    task automatic t_inhibit();
        site_close[6] = 1'b1;
        wait_n(12);
        check(16'({mod_en, power}), 16'h0000);
        site_close[6] = 1'b0;
        wait_n(12);
        check(16'({mod_en, power}), 16'h0164);
    endtask

    task automatic t_ovv();
        ovv = 1'b1;
        wait_n(8);
        check(16'(power), 16'h0000);
        check(16'(alm_oe), 16'h0003);
        ovv = 1'b0;
        wait_n(8);
        check(16'(alm_oe), 16'h0000);
        check(16'(power), 16'h0064);
        check(16'(alm_lamp), 16'h0003);
        press(7);
        check(16'(alm_lamp), 16'h0000);
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        wait_n(2);
        rst_n_in = 1'b1;
        wait_n(12);
        check(16'({oe, trim}), 16'h0028);
        t_select();
        t_local();
        press(2);
        t_trim();
        t_inhibit();
        t_ovv();
        complete_run();
    end
endmodule
